//--- include/i2c_seq_pkg.sv
// Purpose: Constants and types for the I2C master bus-condition sequencer.
// Assumes: 250 MHz system clock, classic Wishbone slave with 32-bit data.
// Notes: Offsets are byte addresses; each register takes one aligned word.
// Functional notes
// - Ack sequence pulls SCL low and puts the ack value on SDA.
// - Ack: half-bit low, release SCL, half-bit high, SCL low, clear, idle.
// - Buffer writes during ack or stop are dropped and flag a write clash.
// - Stop pulls SDA low, then times one half-bit once SDA reads low.
// - Stop releases SCL, then SDA, marks stop seen, then finishes with event.
// - While asleep, an enabled event wakes the processor.
// - Reset or disable aborts any transfer and releases the bus.
// - Start-seen and stop-seen clear on reset and while disabled.
// - A stop detected on a busy bus raises the interrupt when enabled.
// - While sending ones, SDA read low with SCL high is a collision.
// - Transmit collision clears buffer full and releases both lines.
// - Collision in a sequence aborts it, releases lines, clears its request.
// - After collision, bus stops are still detected and set the event flag.
// - A new buffer write after collision starts again at the first bit.
// - Start with SDA or SCL already low aborts and flags a collision.
// - Start times a half-bit with SDA high; SCL low then is a collision.
// - SDA low early shortens start; else SDA low, half-bit, then SCL low.
// - Repeated start waits SDA high, times, releases SCL, checks SDA high.
// - Repeated start: SCL falling before SDA driven low is a collision.
// - Repeated start ends by SDA low, half-bit, then SCL low unconditionally.
// - Two reloads per SCL period; SCL rate is clock/(4*(reload+1)).
package i2c_seq_pkg;
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          ADR_W         = 5;
  localparam int          DAT_W         = 32;
  // Timer ticks every second clock, so one half-bit is 2*(reload+1) clocks.
  localparam int          TICK_DIV      = 2;
  localparam logic [4:0]  CONTROL_ADR   = 5'h00;
  localparam logic [4:0]  SEQUENCE_ADR  = 5'h04;
  localparam logic [4:0]  STATUS_ADR    = 5'h08;
  localparam logic [4:0]  DIVIDER_ADR   = 5'h0C;
  localparam logic [4:0]  BUFFER_ADR    = 5'h10;
  localparam int          CTL_ENABLE    = 0;
  localparam int          CTL_EVENT_EN  = 1;
  localparam int          SEQ_START     = 0;
  localparam int          SEQ_RSTART    = 1;
  localparam int          SEQ_STOP      = 2;
  localparam int          SEQ_ACK_GO    = 3;
  localparam int          SEQ_ACK_VALUE = 4;
  localparam int          SEQ_ACK_STAT  = 5;
  localparam int          STA_BUF_FULL  = 0;
  localparam int          STA_STOP_SEEN = 1;
  localparam int          STA_STRT_SEEN = 2;
  localparam int          STA_EVENT     = 3;
  localparam int          STA_COLLISION = 4;
  localparam int          STA_WCLASH    = 5;
  localparam int          STA_BUSY      = 6;
  localparam logic [7:0]  DIVIDER_RESET = 8'h13;
  localparam logic [3:0]  ACK_BIT_INDEX = 4'h8;

  typedef enum logic [4:0] {
    IDLE, ST_CNT1, ST_CNT2, RS_SDA, RS_CNT1, RS_SCLW, RS_CNT2, RS_CNT3,
    TX_LOW, TX_SCLW, TX_HIGH, AK_LOW, AK_SCLW, AK_HIGH,
    SP_SDAW, SP_CNT1, SP_SCLW, SP_CNT2, SP_SDAW2, SP_CNT3
  } fsm_type;
endpackage

//--- logic/i2c_seq.sv
// Purpose: I2C master sequencer for start, restart, byte send, ack and stop.
// Assumes: Pin inputs are synchronous to clk_i; lines are open drain.
// Notes: A line is pulled low while its output enable is high.
`timescale 1ns/1ns
module i2c_seq
  import i2c_seq_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic                          resetn_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [i2c_seq_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [i2c_seq_pkg::DAT_W-1:0] wb_dat_i,
  output logic      [i2c_seq_pkg::DAT_W-1:0] wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          scl_i,
  output logic                               scl_o,
  output logic                               scl_oe_o,
  input  wire logic                          sda_i,
  output logic                               sda_o,
  output logic                               sda_oe_o,
  input  wire logic                          sleep_i,
  output logic                               irq_o,
  output logic                               wake_o
);
  import i2c_seq_pkg::*;

  typedef struct packed {
    fsm_type             fsm;
    logic                enable;
    logic                event_en;
    logic                ack_value_bit;
    logic                start_req;
    logic                rstart_req;
    logic                stop_sequence_request;
    logic                ack_sequence_go;
    logic                ack_status;
    logic                buffer_full_flag;
    logic                start_seen;
    logic                stop_seen;
    logic                serial_event_flag;
    logic                collision_flag;
    logic                write_clash_flag;
    logic [7:0]          divider_reload;
    logic [7:0]          xfer_buffer;
    logic [7:0]          shreg;
    logic [3:0]          bit_idx;
    logic [7:0]          bit_timer;
    logic                run;
    logic                tick;
    logic                scl_low;
    logic                sda_low;
    logic                scl_prev;
    logic                sda_prev;
    logic                ack;
    logic [DAT_W-1:0]    dat;
    logic                irq;
    logic                wake;
  } state_type;

  state_type st;
  state_type next_st;

  // Arms the bit timer for one half-bit from the reload value.
  function automatic state_type arm(input state_type s);
    state_type r;
    r           = s;
    r.bit_timer = s.divider_reload;
    r.run       = 1'b1;
    r.tick      = 1'b0;
    return r;
  endfunction

  // Collision: drop everything, release both lines and flag it.
  function automatic state_type abort(input state_type s);
    state_type r;
    r                       = s;
    r.fsm                   = IDLE;
    r.scl_low               = 1'b0;
    r.sda_low               = 1'b0;
    r.run                   = 1'b0;
    r.start_req             = 1'b0;
    r.rstart_req            = 1'b0;
    r.stop_sequence_request = 1'b0;
    r.ack_sequence_go       = 1'b0;
    r.buffer_full_flag      = 1'b0;
    r.collision_flag        = 1'b1;
    return r;
  endfunction

  function automatic logic [DAT_W-1:0] read_reg(input state_type s,
                                                input logic [ADR_W-1:0] a);
    logic [DAT_W-1:0] d;
    d = '0;
    case (a)
      CONTROL_ADR:
      begin
        d[CTL_ENABLE]   = s.enable;
        d[CTL_EVENT_EN] = s.event_en;
      end
      SEQUENCE_ADR:
      begin
        d[SEQ_START]     = s.start_req;
        d[SEQ_RSTART]    = s.rstart_req;
        d[SEQ_STOP]      = s.stop_sequence_request;
        d[SEQ_ACK_GO]    = s.ack_sequence_go;
        d[SEQ_ACK_VALUE] = s.ack_value_bit;
        d[SEQ_ACK_STAT]  = s.ack_status;
      end
      STATUS_ADR:
      begin
        d[STA_BUF_FULL]  = s.buffer_full_flag;
        d[STA_STOP_SEEN] = s.stop_seen;
        d[STA_STRT_SEEN] = s.start_seen;
        d[STA_EVENT]     = s.serial_event_flag;
        d[STA_COLLISION] = s.collision_flag;
        d[STA_WCLASH]    = s.write_clash_flag;
        d[STA_BUSY]      = (s.fsm != IDLE);
      end
      DIVIDER_ADR: d[7:0] = s.divider_reload;
      BUFFER_ADR:  d[7:0] = s.xfer_buffer;
      default:     d = '0;
    endcase
    return d;
  endfunction

  logic bus_req;
  logic wr;
  logic expire;
  logic stop_det;
  logic start_det;

  always_comb
  begin
    next_st   = st;
    bus_req   = wb_cyc_i && wb_stb_i && !st.ack;
    wr        = bus_req && wb_we_i && wb_sel_i[0];
    expire    = st.run && st.tick && (st.bit_timer == 8'h00);
    stop_det  = scl_i && st.scl_prev && sda_i && !st.sda_prev;
    start_det = scl_i && st.scl_prev && !sda_i && st.sda_prev;

    next_st.scl_prev = scl_i;
    next_st.sda_prev = sda_i;
    next_st.tick     = !st.tick;
    if (st.run && st.tick && st.bit_timer != 8'h00)
    begin
      next_st.bit_timer = st.bit_timer - 8'h01;
    end
    if (expire)
    begin
      next_st.run = 1'b0;
    end

    // Bus slave: answers one cycle after the request, reads are registered.
    next_st.ack = bus_req;
    next_st.dat = bus_req ? read_reg(st, wb_adr_i) : '0;
    if (wr)
    begin
      case (wb_adr_i)
        CONTROL_ADR:
        begin
          next_st.enable   = wb_dat_i[CTL_ENABLE];
          next_st.event_en = wb_dat_i[CTL_EVENT_EN];
        end
        SEQUENCE_ADR:
        begin
          next_st.ack_value_bit = wb_dat_i[SEQ_ACK_VALUE];
          // Requests made while a sequence runs have no effect.
          if (st.fsm == IDLE && st.enable)
          begin
            next_st.start_req             = wb_dat_i[SEQ_START];
            next_st.rstart_req            = wb_dat_i[SEQ_RSTART];
            next_st.stop_sequence_request = wb_dat_i[SEQ_STOP];
            next_st.ack_sequence_go       = wb_dat_i[SEQ_ACK_GO];
          end
        end
        STATUS_ADR:
        begin
          // Write one to clear; hardware sets below still win.
          if (wb_dat_i[STA_EVENT])
            next_st.serial_event_flag = 1'b0;
          if (wb_dat_i[STA_COLLISION])
            next_st.collision_flag = 1'b0;
          if (wb_dat_i[STA_WCLASH])
            next_st.write_clash_flag = 1'b0;
        end
        DIVIDER_ADR: next_st.divider_reload = wb_dat_i[7:0];
        BUFFER_ADR:
        begin
          if (st.fsm != IDLE)
          begin
            next_st.write_clash_flag = 1'b1;
          end
          else if (st.enable)
          begin
            // Every send restarts from bit 7 of the fresh byte.
            next_st.xfer_buffer      = wb_dat_i[7:0];
            next_st.shreg            = wb_dat_i[7:0];
            next_st.bit_idx          = 4'h0;
            next_st.buffer_full_flag = 1'b1;
            next_st.scl_low          = 1'b1;
            next_st.sda_low          = !wb_dat_i[7];
            next_st.fsm              = TX_LOW;
            next_st                  = arm(next_st);
          end
        end
        default: ;
      endcase
    end

    // Bus monitor keeps running in every state, collisions included.
    if (start_det)
    begin
      next_st.start_seen = 1'b1;
      next_st.stop_seen  = 1'b0;
    end
    if (stop_det)
    begin
      next_st.stop_seen         = 1'b1;
      next_st.start_seen        = 1'b0;
      next_st.serial_event_flag = 1'b1;
    end

    case (st.fsm)
      IDLE:
      begin
        if (st.start_req)
        begin
          if (!sda_i || !scl_i)
            next_st = abort(next_st);
          else
          begin
            next_st     = arm(next_st);
            next_st.fsm = ST_CNT1;
          end
        end
        else if (st.rstart_req)
        begin
          next_st.sda_low = 1'b0;
          next_st.fsm     = RS_SDA;
        end
        else if (st.stop_sequence_request)
        begin
          next_st.sda_low = 1'b1;
          next_st.fsm     = SP_SDAW;
        end
        else if (st.ack_sequence_go)
        begin
          next_st.scl_low = 1'b1;
          next_st.sda_low = !st.ack_value_bit;
          next_st         = arm(next_st);
          next_st.fsm     = AK_LOW;
        end
      end
      ST_CNT1:
      begin
        if (!scl_i && sda_i)
          next_st = abort(next_st);
        else if (!sda_i || expire)
        begin
          next_st.sda_low = 1'b1;
          next_st         = arm(next_st);
          next_st.fsm     = ST_CNT2;
        end
      end
      ST_CNT2:
      begin
        // Another master pulling SCL here is not a loss of arbitration.
        if (expire)
        begin
          next_st.scl_low           = 1'b1;
          next_st.start_req         = 1'b0;
          next_st.serial_event_flag = 1'b1;
          next_st.fsm               = IDLE;
        end
      end
      RS_SDA:
      begin
        if (sda_i)
        begin
          next_st     = arm(next_st);
          next_st.fsm = RS_CNT1;
        end
      end
      RS_CNT1:
      begin
        if (expire)
        begin
          next_st.scl_low = 1'b0;
          next_st.fsm     = RS_SCLW;
        end
      end
      RS_SCLW:
      begin
        if (scl_i)
        begin
          if (!sda_i)
            next_st = abort(next_st);
          else
          begin
            next_st     = arm(next_st);
            next_st.fsm = RS_CNT2;
          end
        end
      end
      RS_CNT2:
      begin
        if (!scl_i && sda_i)
          next_st = abort(next_st);
        else if (expire)
        begin
          next_st.sda_low = 1'b1;
          next_st         = arm(next_st);
          next_st.fsm     = RS_CNT3;
        end
      end
      RS_CNT3:
      begin
        if (expire)
        begin
          next_st.scl_low           = 1'b1;
          next_st.rstart_req        = 1'b0;
          next_st.serial_event_flag = 1'b1;
          next_st.fsm               = IDLE;
        end
      end
      TX_LOW:
      begin
        if (expire)
        begin
          next_st.scl_low = 1'b0;
          next_st.fsm     = TX_SCLW;
        end
      end
      TX_SCLW:
      begin
        if (scl_i)
        begin
          next_st     = arm(next_st);
          next_st.fsm = TX_HIGH;
        end
      end
      TX_HIGH:
      begin
        if (st.bit_idx != ACK_BIT_INDEX && st.shreg[7] && !sda_i)
          next_st = abort(next_st);
        else if (expire)
        begin
          next_st.scl_low = 1'b1;
          if (st.bit_idx == ACK_BIT_INDEX)
          begin
            next_st.ack_status        = sda_i;
            next_st.serial_event_flag = 1'b1;
            next_st.fsm               = IDLE;
          end
          else
          begin
            next_st.shreg   = {st.shreg[6:0], 1'b0};
            next_st.bit_idx = st.bit_idx + 4'h1;
            next_st.sda_low = !st.shreg[6];
            if (st.bit_idx + 4'h1 == ACK_BIT_INDEX)
            begin
              next_st.buffer_full_flag = 1'b0;
              next_st.sda_low          = 1'b0;
            end
            next_st     = arm(next_st);
            next_st.fsm = TX_LOW;
          end
        end
      end
      AK_LOW:
      begin
        if (expire)
        begin
          next_st.scl_low = 1'b0;
          next_st.fsm     = AK_SCLW;
        end
      end
      AK_SCLW:
      begin
        if (scl_i)
        begin
          next_st     = arm(next_st);
          next_st.fsm = AK_HIGH;
        end
      end
      AK_HIGH:
      begin
        if (st.ack_value_bit && !sda_i)
          next_st = abort(next_st);
        else if (expire)
        begin
          next_st.scl_low           = 1'b1;
          next_st.ack_sequence_go   = 1'b0;
          next_st.serial_event_flag = 1'b1;
          next_st.fsm               = IDLE;
        end
      end
      SP_SDAW:
      begin
        if (!sda_i)
        begin
          next_st     = arm(next_st);
          next_st.fsm = SP_CNT1;
        end
      end
      SP_CNT1:
      begin
        if (expire)
        begin
          next_st.scl_low = 1'b0;
          next_st.fsm     = SP_SCLW;
        end
      end
      SP_SCLW:
      begin
        if (scl_i)
        begin
          next_st     = arm(next_st);
          next_st.fsm = SP_CNT2;
        end
      end
      SP_CNT2:
      begin
        if (expire)
        begin
          next_st.sda_low = 1'b0;
          next_st.fsm     = SP_SDAW2;
        end
      end
      SP_SDAW2:
      begin
        if (sda_i && scl_i)
        begin
          next_st     = arm(next_st);
          next_st.fsm = SP_CNT3;
        end
      end
      SP_CNT3:
      begin
        if (expire)
        begin
          next_st.stop_sequence_request = 1'b0;
          next_st.serial_event_flag     = 1'b1;
          next_st.fsm                   = IDLE;
        end
      end
      default: next_st.fsm = IDLE;
    endcase

    // A disabled port holds nothing: lines free, sequences and seen flags off.
    if (!next_st.enable)
    begin
      next_st.fsm                   = IDLE;
      next_st.run                   = 1'b0;
      next_st.scl_low               = 1'b0;
      next_st.sda_low               = 1'b0;
      next_st.start_req             = 1'b0;
      next_st.rstart_req            = 1'b0;
      next_st.stop_sequence_request = 1'b0;
      next_st.ack_sequence_go       = 1'b0;
      next_st.buffer_full_flag      = 1'b0;
      next_st.start_seen            = 1'b0;
      next_st.stop_seen             = 1'b0;
    end
    next_st.irq  = next_st.event_en && next_st.serial_event_flag;
    next_st.wake = sleep_i && next_st.irq;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st                <= '0;
      st.fsm            <= IDLE;
      st.divider_reload <= DIVIDER_RESET;
      st.scl_prev       <= 1'b1;
      st.sda_prev       <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = st.scl_low;
  assign sda_oe_o = st.sda_low;
  assign irq_o    = st.irq;
  assign wake_o   = st.wake;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack lasted more than one cycle");
  a_ack_latency: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_write_clash: assert property (
    wr && wb_adr_i == BUFFER_ADR && st.fsm != IDLE
      |=> st.write_clash_flag && $stable(st.xfer_buffer))
    else $error("busy buffer write not refused");
  a_start_abort: assert property (
    st.fsm == IDLE && st.enable && st.start_req && !sda_i
      |=> st.collision_flag && !st.start_req && !scl_oe_o && !sda_oe_o)
    else $error("start on low bus not aborted");
  a_tx_collision: assert property (
    st.fsm == TX_HIGH && st.bit_idx != ACK_BIT_INDEX && st.shreg[7] && !sda_i
      && st.enable |=> st.collision_flag && !st.buffer_full_flag
      && !scl_oe_o && !sda_oe_o && st.fsm == IDLE)
    else $error("lost arbitration not handled");
  a_ack_drive: assert property (
    st.fsm == AK_LOW |-> scl_oe_o && (sda_oe_o == !st.ack_value_bit))
    else $error("ack phase drives wrong levels");
  a_seen_clear: assert property (
    !st.enable |-> !st.start_seen && !st.stop_seen)
    else $error("seen flags kept while disabled");
  a_stop_event: assert property (
    stop_det && st.enable |=> st.serial_event_flag && st.stop_seen)
    else $error("bus stop not flagged");
  a_irq_follow: assert property (
    stop_det && st.event_en && st.enable ##1 st.event_en |-> irq_o)
    else $error("stop did not raise interrupt");
  a_clock_stretch: assert property (
    st.fsm == AK_SCLW && !scl_i && st.enable |=> st.fsm == AK_SCLW && !st.run)
    else $error("half-bit began before SCL high");
  a_half_bit: assert property (
    st.fsm == AK_SCLW && scl_i && st.enable && !wr
      |=> st.fsm == AK_HIGH [*2])
    else $error("ack high phase shorter than two cycles");

  c_start_done: cover property (st.fsm == ST_CNT2 ##1 st.fsm == IDLE);
  c_ack_done: cover property (st.fsm == AK_HIGH ##1 st.fsm == IDLE);
  c_stop_done: cover property (st.fsm == SP_CNT3 ##1 st.fsm == IDLE);
  c_collision: cover property ($rose(st.collision_flag));
endmodule // i2c_seq

//--- testbench/i2c_far.sv
// Purpose: Far side of the I2C bus: pull-ups, a slow slave, a rival master.
// Assumes: Both lines are open drain with pull-ups.
// Notes: A released line reads high, never a stale level.
`timescale 1ns/1ns
module i2c_far
(
  input  wire logic       clk_i,
  input  wire logic       scl_oe_i,
  input  wire logic       sda_oe_i,
  input  wire logic       hold_sda_i,
  input  wire logic [3:0] stretch_i,
  output logic            scl_o,
  output logic            sda_o
);
  logic [3:0] hold = 4'h0;
  logic       oe_d = 1'b0;
  // The slave keeps SCL low for a while each time the master lets it go.
  always_ff @(posedge clk_i)
  begin
    oe_d <= scl_oe_i;
    if (oe_d && !scl_oe_i && stretch_i != 4'h0)
      hold <= stretch_i - 4'h1;
    else if (hold != 4'h0)
      hold <= hold - 4'h1;
  end
  assign scl_o = !(scl_oe_i || hold != 4'h0 || (oe_d && stretch_i != 4'h0));
  assign sda_o = !(sda_oe_i || hold_sda_i);
endmodule // i2c_far

//--- testbench/tb.sv
// Purpose: Self-checking bench for the I2C bus-condition sequencer.
// Assumes: Divider is kept at 3 or more.
// Notes: Bus polling is slow, so waits are counted in register reads.
`timescale 1ns/1ns
module tb;
  import i2c_seq_pkg::*;
`define CHK(g, e) check(32'(g), 32'(e))
  logic        clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, sleep = 1'b0, hold_sda = 1'b0, meas = 1'b0;
  logic        scl, sda, scl_oe, sda_oe, ack, irq, wake, av;
  logic        scl_v, sda_v;
  logic [4:0]  adr = 5'h00;
  logic [3:0]  stretch = 4'h0;
  logic [31:0] dat = 32'h0, dat_o, rd;
  int          n_errors = 0, total_checks = 0, cnt = 0, d;
  int          seed = 32'h69322D03;
  always #2 clk = !clk;
  always @(posedge clk)
    if (meas && scl && !scl_oe)
      cnt++;
  i2c_seq i_dut (.clk_i(clk), .resetn_i(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .scl_i(scl),
    .scl_o(scl_v), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_v),
    .sda_oe_o(sda_oe),
    .sleep_i(sleep), .irq_o(irq), .wake_o(wake));
  i2c_far i_far (.clk_i(clk), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
    .hold_sda_i(hold_sda), .stretch_i(stretch), .scl_o(scl), .sda_o(sda));
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Expected half-bit length in clocks for a given divider reload.
  function automatic int half_bit(input int r);
    return TICK_DIV * (r + 1);
  endfunction
  task automatic finish_test();
    $display("errors=%0d checks=%0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input int v);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= v;
    for (n = 0; n < 20 && ack !== 1'b1; n++)
      @(posedge clk);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      n_errors++;
      finish_test();
    end
  endtask
  task automatic wait_bit(input logic [4:0] a, input int b, input logic v);
    int n;
    for (n = 0; n < 200; n++)
    begin
      wb(1'b0, a, 0);
      if (rd[b] === v)
        break;
    end
    if (n == 200)
    begin
      n_errors++;
      finish_test();
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    wb(1'b0, STATUS_ADR, 0);
    `CHK(rd, 32'h0);
    wb(1'b0, DIVIDER_ADR, 0);
    `CHK(rd, 32'h13);
    wb(1'b0, 5'h1C, 0);
    `CHK(rd, 32'h0);
    d = 3 + $unsigned($random(seed)) % 4;
    wb(1'b1, DIVIDER_ADR, d);
    wb(1'b1, CONTROL_ADR, 3);
    // A rival already holds SDA low, so the start must give up.
    hold_sda <= 1'b1;
    wb(1'b1, SEQUENCE_ADR, 1);
    wait_bit(STATUS_ADR, STA_COLLISION, 1'b1);
    wb(1'b0, SEQUENCE_ADR, 0);
    `CHK(rd[0], 0);
    `CHK({scl_oe, sda_oe}, 0);
    hold_sda <= 1'b0;
    wb(1'b1, STATUS_ADR, 32'h38);
    wb(1'b1, SEQUENCE_ADR, 1);
    wait_bit(STATUS_ADR, STA_EVENT, 1'b1);
    wb(1'b1, STATUS_ADR, 32'h38);
    wb(1'b1, BUFFER_ADR, 32'hFF);
    hold_sda <= 1'b1;
    wait_bit(STATUS_ADR, STA_COLLISION, 1'b1);
    `CHK(rd[STA_BUF_FULL], 0);
    `CHK({scl_oe, sda_oe}, 0);
    // The rival then closes its frame with a stop on the bus.
    wb(1'b1, STATUS_ADR, 32'h38);
    hold_sda <= 1'b0;
    wait_bit(STATUS_ADR, STA_EVENT, 1'b1);
    `CHK(rd[STA_STOP_SEEN], 1);
    `CHK(irq, 1);
    `CHK(wake, 0);
    wb(1'b1, STATUS_ADR, 32'h38);
    // At least one cycle of stretch so the wait for SCL high is exercised.
    stretch <= 4'(1 + $unsigned($random(seed)) % 7);
    av = 1'($random(seed));
    wb(1'b1, SEQUENCE_ADR, 1);
    wait_bit(STATUS_ADR, STA_EVENT, 1'b1);
    wb(1'b1, STATUS_ADR, 32'h38);
    cnt = 0;
    meas <= 1'b1;
    wb(1'b1, SEQUENCE_ADR, {27'h0, av, 4'h8});
    repeat (3) @(posedge clk);
    #1;
    `CHK({scl_oe, sda_oe}, {1'b1, !av});
    wb(1'b1, BUFFER_ADR, 32'hA5);
    wait_bit(SEQUENCE_ADR, SEQ_ACK_GO, 1'b0);
    meas <= 1'b0;
    `CHK(cnt >= half_bit(d) && cnt <= half_bit(d) + 3, 1);
    `CHK(scl_oe, 1);
    wb(1'b0, STATUS_ADR, 0);
    `CHK(rd[STA_WCLASH], 1);
    `CHK(rd[STA_BUF_FULL], 0);
    wb(1'b1, STATUS_ADR, 32'h38);
    sleep <= 1'b1;
    wb(1'b1, SEQUENCE_ADR, 4);
    repeat (3) @(posedge clk);
    #1;
    `CHK(sda_oe, 1);
    `CHK({scl_v, sda_v}, 0);
    wait_bit(STATUS_ADR, STA_EVENT, 1'b1);
    `CHK(rd[STA_STOP_SEEN], 1);
    `CHK({scl_oe, sda_oe}, 0);
    `CHK(wake, 1);
    wb(1'b1, CONTROL_ADR, 0);
    wb(1'b0, STATUS_ADR, 0);
    `CHK(rd[STA_STOP_SEEN], 0);
    wb(1'b1, CONTROL_ADR, 3);
    wb(1'b1, SEQUENCE_ADR, 1);
    repeat (5) @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({scl_oe, sda_oe, irq, wake}, 0);
    @(posedge clk);
    resetn <= 1'b1;
    wb(1'b0, DIVIDER_ADR, 0);
    `CHK(rd, DIVIDER_RESET);
    finish_test();
  end
endmodule // tb
